/* i2cm_pkg.sv */
package i2cm_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [4:0] OFS_CTRL1 = 5'h00;
  localparam logic [4:0] OFS_CTRL2 = 5'h04;
  localparam logic [4:0] OFS_MODE = 5'h08;
  localparam logic [4:0] OFS_IEN = 5'h0C;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam logic [4:0] OFS_TXD = 5'h14;
  localparam logic [4:0] OFS_RXD = 5'h18;
  // ----------------------------------------
  // Bit positions
  // ----------------------------------------
  localparam int B_ENABLE = 7;
  localparam int B_RXDIS = 6;
  localparam int B_MST = 5;
  localparam int B_TRS = 4;
  localparam int B_BUS_BUSY = 7;
  localparam int B_SCP = 6;
  localparam int B_DATA_LINE_OUTPUT = 5;
  localparam int B_DATA_LINE_WRITE_PROTECT = 4;
  localparam int B_CLOCK_LINE_MONITOR = 3;
  localparam int B_CURST = 1;
  localparam int B_MLS = 7;
  localparam int B_WAIT = 6;
  localparam int B_BIT_COUNT_WRITE_PROTECT = 3;
  localparam int B_ACK_CHECK_ENABLE = 2;
  localparam int B_ACK_RECEIVED = 1;
  localparam int B_ACK_TO_SEND = 0;
  localparam int B_TX_EMPTY_FLAG = 7;
  localparam int B_TX_DONE_FLAG = 6;
  localparam int B_RX_FULL_FLAG = 5;
  localparam int B_NACK = 4;
  localparam int B_STOP = 3;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h30;
  localparam logic [7:0] RST_IEN = 8'h00;
  localparam logic [7:0] RST_TXD = 8'hFF;
  localparam logic [7:0] RST_RXD = 8'hFF;
  localparam int CLK_HZ = 50000000;
  localparam int SCL_FAST_HZ = 400000;
  // Quarter-bit period in cycles for rate select 0101, which gives 400 kHz
  localparam int QTR_FAST = CLK_HZ / (SCL_FAST_HZ * 4);
  localparam logic [3:0] CKS_FAST = 4'h5;
  // ----------------------------------------
  // Bus engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BIT = 3'b010,
    ST_STOP = 3'b011,
    ST_HOLD = 3'b100
  } i2cm_state_type;
endpackage

/* i2cm_props.sv */
`timescale 1ns/10ps
module i2cm_props (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // Register bus handshakes
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_RRESP,
  // Bus pins
  input wire logic O_SCL,
  input wire logic O_SDA,
  input wire logic O_SCL_OE,
  input wire logic O_SDA_OE
);
  // ------------------------------
  // Port timing and value checks
  // ------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  pins_open_drain_a: assert property (!O_SCL && !O_SDA) else $error("pin driven high");
  reset_quiet_a: assert property ($rose(I_RST_B) |-> !O_SCL_OE && !O_SDA_OE && !O_BVALID)
    else $error("busy after reset");
  write_answer_a: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
    else $error("write answer late");
  resp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP)) else $error("b dropped");
  resp_code_a: assert property (O_BVALID |-> O_BRESP == 2'b00 || O_BRESP == 2'b10) else $error("bad bresp");
  read_answer_a: assert property (I_ARVALID && O_ARREADY && !O_RVALID |=> O_RVALID) else $error("read late");
  data_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("r dropped");
  upper_zero_a: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000) else $error("upper bits set");
  read_code_a: assert property (O_RVALID |-> O_RRESP == 2'b00 || O_RRESP == 2'b10) else $error("bad rresp");
  // Main scenarios reached
  write_done_c: cover property (O_BVALID && I_BREADY);
  read_done_c: cover property (O_RVALID && I_RREADY);
  clock_pulse_c: cover property ($fell(O_SCL_OE));
endmodule
bind i2cm_top i2cm_props u_props (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY), .O_BRESP(O_BRESP), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
  .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_SCL(O_SCL), .O_SDA(O_SDA),
  .O_SCL_OE(O_SCL_OE), .O_SDA_OE(O_SDA_OE));

/* i2cm_slave_model.sv */
`timescale 1ns/10ps
module i2cm_slave_model (
  // Bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  // Refusal and read data base
  input wire logic i_nack,
  input wire logic [7:0] i_base,
  // Line drive and what was seen
  output logic o_sda_oe,
  output logic o_busy,
  output logic o_mack,
  output logic [7:0] o_byte
);
  int cnt = -1;
  logic rd = 1'b0;
  logic first = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [7:0] k = 8'h00;
  initial {o_sda_oe, o_busy, o_mack, o_byte} = 11'h000;
  // Start seen while the clock line is high
  always @(negedge i_sda) if (i_scl) begin
    {cnt, first, rd, k, o_mack} = {-32'sd1, 1'b1, 1'b0, 8'h00, 1'b0};
    o_busy = 1'b1;
  end
  // Stop seen while the clock line is high
  always @(posedge i_sda) if (i_scl) {o_busy, o_sda_oe} = 2'b00;
  // Write data in MSB first, master acknowledge out
  always @(posedge i_scl) if (o_busy) begin
    if (cnt >= 0 && cnt < 8 && !rd) sh = {sh[6:0], i_sda};
    if (cnt == 8 && rd) o_mack = i_sda;
  end
  // Nine clocks a unit; line changes only while the clock is low
  always @(negedge i_scl) if (o_busy) begin
    if (cnt == 7) begin
      cnt = 8;
      if (!rd) o_byte = sh;
      o_sda_oe = (first || !rd) && !i_nack;
      if (first) rd = sh[0];
      first = 1'b0;
    end else if (cnt == 8) begin
      cnt = 0;
      if (rd && o_mack) o_busy = 1'b0;
      tx = i_base + k;
      k = k + 8'h01;
      o_sda_oe = rd && o_busy && !tx[7];
    end else begin
      cnt = cnt + 1;
      o_sda_oe = rd && !tx[7 - cnt];
    end
  end
endmodule

/* i2cm_top.sv */
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Function
// - Enable bit lets the controller drive SCL/SDA; clear means no transfers.
// - In master receive with receive-disable clear, reading receive data starts the next byte.
// - Master and transmit bits pick role: 10 master receive, 11 master transmit.
// - Rate select 0101 gives a 400 kHz SCL.
// - Writing busy/start-stop pair 10 generates a start condition.
// - Writing busy/start-stop pair 00 generates a stop condition.
// - Busy bit shows bus occupied; zero means released.
// - Data-line bit reads 1 when SDA output high; writing 1 releases SDA, writing 0 pulls it low.
// - Clock monitor bit is read-only, 1 when SCL output high.
// - Writing 1 to control-unit reset resets the control circuitry.
// - With wait bit clear, data and acknowledge run back to back.
// - Bit count 000 makes nine-bit transfers, eight data plus acknowledge.
// - Enable bits 7..3 gate the five interrupt requests individually.
// - With ack check on, a received acknowledge of 1 halts transfer.
// - In transmit mode the slave's acknowledge is captured read-only.
// - In receive mode the master sends the acknowledge-to-send value.
// - Status bits: tx empty 7, tx end 6, rx full 5, nack 4, stop 3, 2,1,0.
// - Receive data is read-only, holding the latest completed byte.
// - Transmit-end flag sets after the acknowledge bit that follows the byte.
// - In master receive a dummy read of receive data starts SCL clocks.
// - Transmit data moves to the shift register, then tx empty sets.
// - Receive-full sets on byte transfer to receive register, clears on read.
module i2cm_top #(
  parameter int QTR_DEFAULT = i2cm_pkg::QTR_FAST
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // AXI4-Lite write address
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [4:0] I_AWADDR,
  // AXI4-Lite write data
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // AXI4-Lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [4:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // I2C pins, open drain
  input wire logic I_SCL,
  output logic O_SCL,
  output logic O_SCL_OE,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // Interrupt requests
  output logic O_TX_EMPTY_IRQ,
  output logic O_TX_DONE_IRQ,
  output logic O_RX_FULL_IRQ,
  output logic O_NO_ACK_IRQ,
  output logic O_STOP_SEEN_IRQ
);
  import i2cm_pkg::*;

  // Below three cycles a quarter bit leaves no time to see SCL high
  if (QTR_DEFAULT < 3) begin : g_qtr_check
    $error("QTR_DEFAULT too small");
  end

  typedef struct packed {
    logic awp;
    logic [4:0] awa;
    logic wp;
    logic [31:0] wd;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [7:0] ctl1;
    logic bus_busy;
    logic data_line_output;
    logic [7:0] mode;
    logic [7:0] ien;
    logic ack_received;
    logic tx_empty_flag, tx_done_flag, rx_full_flag, nack, stp;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [7:0] sh;
    logic txv;
    i2cm_state_type st;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [15:0] cnt;
    logic scl, sda;
    logic go_rx;
    logic [1:0] scl_s, sda_s;
    logic [4:0] irq;
    logic aw_rdy, w_rdy, ar_rdy, scl_oe, sda_oe;
  } i2cm_state_s_type;

  i2cm_state_s_type r_ff, nxt_r;
  logic [15:0] qtr;
  logic [3:0] nbits;
  logic wr_go, rd_go, tick, cu_rst;
  logic [4:0] wa;
  logic [7:0] wb;

  // ----------------------------------------
  // Rate and bit count decode
  // ----------------------------------------
  always_comb begin
    // Counter reload is one less than the quarter-bit length
    if (r_ff.ctl1[3:0] == CKS_FAST) begin
      qtr = 16'(QTR_DEFAULT) - 16'h0001;
    end else begin
      qtr = (16'(QTR_DEFAULT) << r_ff.ctl1[3:2]) - 16'h0001;
    end
    if (r_ff.mode[2:0] == 3'b000) begin
      nbits = 4'h9;
    end else begin
      nbits = {1'b0, r_ff.mode[2:0]} + 4'h1;
    end
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.scl_s = {r_ff.scl_s[0], I_SCL};
    nxt_r.sda_s = {r_ff.sda_s[0], I_SDA};
    tick = (r_ff.cnt == 16'h0000);
    // Bus handshakes
    if (I_AWVALID && O_AWREADY) begin
      nxt_r.awp = 1'b1;
      nxt_r.awa = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      nxt_r.wp = 1'b1;
      nxt_r.wd = I_WDATA;
    end
    if (r_ff.bv && I_BREADY) nxt_r.bv = 1'b0;
    if (r_ff.rv && I_RREADY) nxt_r.rv = 1'b0;
    wr_go = r_ff.awp && r_ff.wp && !r_ff.bv;
    rd_go = I_ARVALID && !r_ff.rv;
    wa = r_ff.awa;
    wb = r_ff.wd[7:0];
    cu_rst = wr_go && (wa == OFS_CTRL2) && wb[B_CURST]; // Soft reset beats a same-cycle tick
    // Register write, low byte lane only
    if (wr_go) begin
      nxt_r.awp = 1'b0;
      nxt_r.wp = 1'b0;
      nxt_r.bv = 1'b1;
      nxt_r.br = 2'b00;
      case (wa)
        OFS_CTRL1: nxt_r.ctl1 = wb;
        OFS_CTRL2: begin
          if (wb[B_CURST]) begin
            nxt_r.st = ST_IDLE;
            nxt_r.bus_busy = 1'b0;
            nxt_r.scl = 1'b1;
            nxt_r.sda = 1'b1;
            nxt_r.txv = 1'b0;
            nxt_r.go_rx = 1'b0;
          end else if (!wb[B_BUS_BUSY] && !wb[B_SCP] && r_ff.bus_busy) begin
            nxt_r.st = ST_STOP;
            nxt_r.ph = 2'd0;
            nxt_r.cnt = qtr;
          end else if (wb[B_BUS_BUSY] && !wb[B_SCP] && r_ff.ctl1[B_ENABLE] && r_ff.ctl1[B_MST]) begin
            nxt_r.st = ST_START;
            nxt_r.ph = 2'd0;
            nxt_r.cnt = qtr;
          end
          if (!wb[B_DATA_LINE_WRITE_PROTECT]) nxt_r.data_line_output = wb[B_DATA_LINE_OUTPUT];
        end
        OFS_MODE: begin
          nxt_r.mode[7:4] = wb[7:4];
          if (!wb[B_BIT_COUNT_WRITE_PROTECT]) nxt_r.mode[2:0] = wb[2:0];
        end
        OFS_IEN: begin
          nxt_r.ien[7:2] = wb[7:2];
          nxt_r.ien[0] = wb[0];
        end
        OFS_STAT: begin
          // Flags clear by writing 0
          nxt_r.tx_empty_flag = r_ff.tx_empty_flag & wb[B_TX_EMPTY_FLAG];
          nxt_r.tx_done_flag = r_ff.tx_done_flag & wb[B_TX_DONE_FLAG];
          nxt_r.rx_full_flag = r_ff.rx_full_flag & wb[B_RX_FULL_FLAG];
          nxt_r.nack = r_ff.nack & wb[B_NACK];
          nxt_r.stp = r_ff.stp & wb[B_STOP];
        end
        OFS_TXD: begin
          nxt_r.txd = wb;
          nxt_r.txv = 1'b1;
          nxt_r.tx_empty_flag = 1'b0;
        end
        default: nxt_r.br = 2'b10;
      endcase
    end
    // Register read
    if (rd_go) begin
      nxt_r.rv = 1'b1;
      nxt_r.rr = 2'b00;
      nxt_r.rd = 32'h0000_0000;
      case (I_ARADDR)
        OFS_CTRL1: nxt_r.rd[7:0] = r_ff.ctl1;
        OFS_CTRL2: nxt_r.rd[7:0] = {r_ff.bus_busy, 1'b0, r_ff.data_line_output & r_ff.sda, 1'b1,
          r_ff.scl, 3'b101};
        OFS_MODE: nxt_r.rd[7:0] = r_ff.mode | 8'h08;
        OFS_IEN: nxt_r.rd[7:0] = {r_ff.ien[7:2], r_ff.ack_received, r_ff.ien[0]};
        OFS_STAT: nxt_r.rd[7:0] = {r_ff.tx_empty_flag, r_ff.tx_done_flag, r_ff.rx_full_flag, r_ff.nack, r_ff.stp, 3'b000};
        OFS_TXD: nxt_r.rd[7:0] = r_ff.txd;
        OFS_RXD: begin
          nxt_r.rd[7:0] = r_ff.rxd;
          nxt_r.rx_full_flag = 1'b0;
          if (!r_ff.ctl1[B_MST] || r_ff.ctl1[B_TRS] || r_ff.ctl1[B_RXDIS]) begin
            nxt_r.go_rx = r_ff.go_rx;
          end else begin
            nxt_r.go_rx = 1'b1;
          end
        end
        default: nxt_r.rr = 2'b10;
      endcase
    end
    // Bus engine, quarter-bit timebase
    nxt_r.cnt = (tick || r_ff.st == ST_IDLE || r_ff.st == ST_HOLD) ? nxt_r.cnt : r_ff.cnt - 16'h0001;
    if (!r_ff.ctl1[B_ENABLE] || cu_rst) begin
      nxt_r.st = ST_IDLE;
      nxt_r.scl = 1'b1;
      nxt_r.sda = 1'b1;
      nxt_r.bus_busy = 1'b0;
    end else if (tick) begin
      nxt_r.cnt = qtr;
      nxt_r.ph = r_ff.ph + 2'd1;
      case (r_ff.st)
        ST_START: begin
          case (r_ff.ph)
            2'd0: begin
              nxt_r.scl = 1'b1;
              nxt_r.sda = 1'b1;
            end
            2'd1: nxt_r.sda = 1'b0;
            2'd2: nxt_r.scl = 1'b0;
            default: begin
              nxt_r.bus_busy = 1'b1;
              nxt_r.tx_empty_flag = 1'b1;
              nxt_r.st = ST_HOLD;
            end
          endcase
        end
        ST_BIT: begin
          case (r_ff.ph)
            2'd0: begin
              if (r_ff.bitn == nbits - 4'h1) begin
                // Acknowledge slot, back to back with data
                nxt_r.sda = (r_ff.ctl1[B_TRS]) ? 1'b1 : r_ff.ien[B_ACK_TO_SEND];
              end else if (r_ff.ctl1[B_TRS]) begin
                nxt_r.sda = r_ff.mode[B_MLS] ? r_ff.sh[0] : r_ff.sh[7];
              end else begin
                nxt_r.sda = 1'b1;
              end
            end
            2'd1: nxt_r.scl = 1'b1;
            2'd2: begin
              if (r_ff.scl_s[1]) begin
                if (r_ff.bitn == nbits - 4'h1) begin
                  if (r_ff.ctl1[B_TRS]) begin
                    nxt_r.ack_received = r_ff.sda_s[1];
                    nxt_r.nack = r_ff.sda_s[1] | nxt_r.nack;
                  end
                end else if (r_ff.mode[B_MLS]) begin
                  nxt_r.sh = {r_ff.sda_s[1], r_ff.sh[7:1]};
                end else begin
                  nxt_r.sh = {r_ff.sh[6:0], r_ff.sda_s[1]};
                end
              end else begin
                nxt_r.ph = r_ff.ph; // Clock stretching
              end
            end
            default: begin
              nxt_r.scl = 1'b0;
              nxt_r.bitn = r_ff.bitn + 4'h1;
              if (r_ff.bitn == nbits - 4'h1) begin
                nxt_r.st = ST_HOLD;
                if (r_ff.ctl1[B_TRS]) begin
                  nxt_r.tx_done_flag = 1'b1;
                end else begin
                  nxt_r.rxd = r_ff.sh;
                  nxt_r.rx_full_flag = 1'b1;
                end
              end
            end
          endcase
        end
        ST_STOP: begin
          case (r_ff.ph)
            2'd0: nxt_r.sda = 1'b0;
            2'd1: nxt_r.scl = 1'b1;
            2'd2: nxt_r.sda = 1'b1;
            default: begin
              nxt_r.bus_busy = 1'b0;
              nxt_r.stp = 1'b1;
              nxt_r.st = ST_IDLE;
            end
          endcase
        end
        default: nxt_r.ph = 2'd0;
      endcase
    end
    // Launch next byte from hold
    if (r_ff.ctl1[B_ENABLE] && r_ff.st == ST_HOLD && nxt_r.st == ST_HOLD) begin
      if (r_ff.ien[B_ACK_CHECK_ENABLE] && r_ff.ack_received && r_ff.ctl1[B_TRS]) begin
        nxt_r.st = ST_HOLD;
      end else if (r_ff.ctl1[B_MST] && r_ff.ctl1[B_TRS] && r_ff.txv) begin
        nxt_r.sh = r_ff.txd;
        nxt_r.txv = 1'b0;
        nxt_r.tx_empty_flag = 1'b1;
        nxt_r.st = ST_BIT;
        nxt_r.bitn = 4'h0;
        nxt_r.ph = 2'd0;
        nxt_r.cnt = qtr;
      end else if (r_ff.ctl1[B_MST] && !r_ff.ctl1[B_TRS] && r_ff.go_rx) begin
        nxt_r.go_rx = 1'b0;
        nxt_r.st = ST_BIT;
        nxt_r.bitn = 4'h0;
        nxt_r.ph = 2'd0;
        nxt_r.cnt = qtr;
      end
    end
    // Interrupt request gating
    nxt_r.irq = nxt_r.ien[7:3] & {nxt_r.tx_empty_flag, nxt_r.tx_done_flag, nxt_r.rx_full_flag, nxt_r.nack, nxt_r.stp};
    // Ready and pin-drive outputs kept in flip-flops
    nxt_r.aw_rdy = !nxt_r.awp;
    nxt_r.w_rdy = !nxt_r.wp;
    nxt_r.ar_rdy = !nxt_r.rv;
    nxt_r.scl_oe = !nxt_r.scl;
    nxt_r.sda_oe = !(nxt_r.sda & nxt_r.data_line_output);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      r_ff <= '0;
      r_ff.ctl1 <= RST_CTRL1;
      r_ff.mode <= RST_MODE;
      r_ff.ien <= RST_IEN;
      r_ff.txd <= RST_TXD;
      r_ff.rxd <= RST_RXD;
      r_ff.data_line_output <= 1'b1;
      r_ff.scl <= 1'b1;
      r_ff.sda <= 1'b1;
      r_ff.scl_s <= 2'b11;
      r_ff.sda_s <= 2'b11;
      r_ff.st <= ST_IDLE;
      r_ff.aw_rdy <= 1'b1;
      r_ff.w_rdy <= 1'b1;
      r_ff.ar_rdy <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign O_AWREADY = r_ff.aw_rdy;
  assign O_WREADY = r_ff.w_rdy;
  assign O_BVALID = r_ff.bv;
  assign O_BRESP = r_ff.br;
  assign O_ARREADY = r_ff.ar_rdy;
  assign O_RVALID = r_ff.rv;
  assign O_RDATA = r_ff.rd;
  assign O_RRESP = r_ff.rr;
  assign O_SCL = 1'b0;
  assign O_SCL_OE = r_ff.scl_oe;
  assign O_SDA = 1'b0;
  assign O_SDA_OE = r_ff.sda_oe;
  assign {O_TX_EMPTY_IRQ, O_TX_DONE_IRQ, O_RX_FULL_IRQ, O_NO_ACK_IRQ, O_STOP_SEEN_IRQ} = r_ff.irq;
endmodule

/* tb_i2cm_top.sv */
`timescale 1ns/10ps
module tb_i2cm_top;
  import i2cm_pkg::*;
  // ------------------------------
  // Bench signals and helpers
  // ------------------------------
  localparam int QTR = 3;
  logic clk, rst_b, awv, wv, bre, arv, rre, nack, awr, wrdy, bv, arr, rv;
  logic scl_o, scl_oe, sda_o, sda_oe, s_oe, s_busy, s_mack;
  logic [4:0] awa, ara, irq;
  logic [31:0] wd, rdat;
  logic [1:0] bresp, rresp;
  logic [7:0] base, s_byte;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || s_oe);
  int fails = 0;
  int n_checks = 0;
  int rises = 0;
  int per = 0;
  int last = 0;
  i2cm_top #(.QTR_DEFAULT(QTR)) DUT (.I_CLK(clk), .I_RST_B(rst_b), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv),
    .I_BREADY(bre), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv),
    .I_RREADY(rre), .O_RDATA(rdat), .O_RRESP(rresp), .I_SCL(scl), .O_SCL(scl_o), .O_SCL_OE(scl_oe),
    .I_SDA(sda), .O_SDA(sda_o), .O_SDA_OE(sda_oe), .O_TX_EMPTY_IRQ(irq[4]), .O_TX_DONE_IRQ(irq[3]),
    .O_RX_FULL_IRQ(irq[2]), .O_NO_ACK_IRQ(irq[1]), .O_STOP_SEEN_IRQ(irq[0]));
  i2cm_slave_model u_slave (.i_scl(scl), .i_sda(sda), .i_nack(nack), .i_base(base), .o_sda_oe(s_oe),
    .o_busy(s_busy), .o_mack(s_mack), .o_byte(s_byte));
  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Clock line rises counted and spaced
  always @(posedge scl) begin
    rises++;
    per = int'($time) - last;
    last = int'($time);
  end
  // Hang guard
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    summarize();
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    {awv, wv, bre} <= 3'b111;
    awa <= a;
    wd <= {24'h000000, d};
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    {arv, rre} <= 2'b11;
    ara <= a;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    r = rresp;
    rre <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d & m, e);
  endtask
  task automatic wflag(input int b);
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0;
    for (int i = 0; i < 300 && d[b] !== 1'b1; i++) rd(OFS_STAT, d, r);
    chk(d[b], 1'b1);
  endtask
  task automatic send(input logic [7:0] b);
    rises = 0;
    wr(OFS_TXD, b);
    wflag(B_TX_DONE_FLAG);
    chk(rises, 9);
    chk(per, QTR * 80);
    chk(s_byte, b);
    rchk(OFS_IEN, {30'h0, nack, 1'b0}, 32'h2);
    rchk(OFS_STAT, {27'h0, nack, 4'h0}, 32'h10);
    chk(irq[1], nack);
    wr(OFS_STAT, 8'hB0);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {rst_b, awv, wv, bre, arv, rre, nack, awa, ara, wd, base} = '0;
    void'($urandom(32'h0D027A79));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk(OFS_CTRL1, RST_CTRL1, 32'hFF);
    // Count write-protect reads back as 1
    rchk(OFS_MODE, RST_MODE | (8'h01 << B_BIT_COUNT_WRITE_PROTECT), 32'hFF);
    rchk(OFS_IEN, RST_IEN, 32'hFF);
    rchk(OFS_CTRL2, 32'h28, 32'h28);
    rd(5'h1C, d, r);
    chk(r, 2'b10);
    wr(OFS_RXD, 8'h00);
    rchk(OFS_RXD, RST_RXD, 32'hFFFFFFFF);
    chk({scl_oe, sda_oe}, 2'b00);
    wr(OFS_MODE, 8'h3B);
    rchk(OFS_MODE, 32'h38, 32'hFF);
    $display("test reset done");
    wr(OFS_MODE, 8'h30);
    wr(OFS_CTRL1, 8'hB5);
    wr(OFS_IEN, 8'h90);
    wr(OFS_CTRL2, 8'hB0);
    wflag(B_TX_EMPTY_FLAG);
    rchk(OFS_CTRL2, 32'h80, 32'h80);
    chk(irq[4], 1'b1);
    chk(s_busy, 1'b1);
    send({7'($urandom), 1'b0});
    send(8'h00);
    send(8'hFF);
    send(8'($urandom));
    nack = 1'b1;
    send(8'($urandom));
    wr(OFS_IEN, 8'h04);
    chk(irq[1], 1'b0);
    rises = 0;
    wr(OFS_TXD, 8'h5A);
    repeat (150) @(posedge clk);
    chk(rises, 0);
    wr(OFS_CTRL2, 8'h72);
    repeat (20) @(posedge clk);
    chk({scl_oe, sda_oe}, 2'b00);
    nack = 1'b0;
    $display("test transmit done");
    base = 8'($urandom);
    wr(OFS_IEN, 8'h20);
    wr(OFS_STAT, 8'h00);
    wr(OFS_CTRL2, 8'hB0);
    wflag(B_TX_EMPTY_FLAG);
    send({7'($urandom), 1'b1});
    wr(OFS_CTRL1, 8'hA5);
    wr(OFS_STAT, 8'h00);
    rd(OFS_RXD, d, r);
    for (int i = 0; i < 3; i++) begin
      wflag(B_RX_FULL_FLAG);
      chk(irq[2], 1'b1);
      if (i == 1) wr(OFS_IEN, 8'h21);
      if (i == 2) wr(OFS_CTRL1, 8'hE5);
      rchk(OFS_RXD, 8'(base + i), 32'hFF);
      chk(s_mack, i == 2);
    end
    rises = 0;
    repeat (100) @(posedge clk);
    chk(rises, 0);
    rchk(OFS_STAT, 32'h0, 32'h20);
    wr(OFS_STAT, 8'h00);
    wr(OFS_CTRL2, 8'h30);
    wflag(B_STOP);
    rchk(OFS_CTRL2, 32'h0, 32'h80);
    chk(s_busy, 1'b0);
    wr(OFS_IEN, 8'hC8);
    chk(irq, 5'h01);
    wr(OFS_CTRL2, 8'h00);
    chk(sda_oe, 1'b1);
    rchk(OFS_CTRL2, 32'h0, 32'h20);
    wr(OFS_CTRL2, 8'h30);
    chk(sda_oe, 1'b1);
    wr(OFS_CTRL2, 8'h20);
    chk(sda_oe, 1'b0);
    $display("test receive done");
    summarize();
  end
endmodule
